// file: bench/spl_position_loop_bench.sv
// Self-checking bench for the steering position loop.
// Assumes the valve model beside it and a 10-cycle tick to keep runs short.
`timescale 1ns/1ps
module spl_position_loop_bench;
  import spl_pkg::*;
  localparam int TD = 10;
  logic mclk, rst_n, awValid, wValid, bReady, arValid, rReady, useMdl;
  logic awReady, wReady, bValid, arReady, rValid, neutral, bridge, strobe;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData, d;
  logic [1:0] bResp, rResp, resp;
  logic signed [15:0] sp, tbPos, ws, absPos, actPos, flow;
  logic [15:0] sens, sensAdj;
  logic [15:0] rstTab [9] = '{RST_GAIN, RST_MAX_FLOW, RST_BASE_FLOW, RST_STROKE,
    RST_DRIFT_GAIN, RST_DRIFT_LIM, RST_HOLD_TIME, RST_THRESHOLD, RST_RELEASE};
  int nErrors = 0, numChecks = 0, cyc = 0, seed = 32'hCCD2, k, g, b, m, s, e;

  spl_position_loop #(.TICK_DIV(TD)) DUT (.mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .posSetpoint(sp),
    .posMeasured(useMdl ? actPos : tbPos), .wheelSpeed(ws), .wheelAbsPos(absPos),
    .sensitivity(sens), .flowCmd(flow), .spoolNeutral(neutral),
    .bridgeEnable(bridge), .sensitivityAdj(sensAdj), .statusStrobe(strobe));
  spl_valve_model VALVE (.mclk(mclk), .flowCmd(flow), .spoolNeutral(neutral),
    .bridgeEnable(bridge), .actPos(actPos));

  // ----------------------------------------------------------------------
  // Clock, hang guard, common tasks
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Run needs about 3k cycles; 10k means a hang
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      nErrors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("Checks %0d, errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Leading edge keeps a new request off the edge that released the last
  task automatic axiWr(input logic [11:0] a, input int v);
    @(posedge mclk);
    awAddr <= a; wData <= v; awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
    do @(posedge mclk); while (awReady !== 1'b1);
    awValid <= 1'b0; wValid <= 1'b0;
    while (bValid !== 1'b1) @(posedge mclk);
    bReady <= 1'b0; resp = bResp;
  endtask
  task automatic axiRd(input logic [11:0] a);
    @(posedge mclk);
    arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
    do @(posedge mclk); while (arReady !== 1'b1);
    arValid <= 1'b0;
    while (rValid !== 1'b1) @(posedge mclk);
    rReady <= 1'b0; d = rData; resp = rResp;
  endtask
  // Bounded poll of one loop output; a stuck level fails the check after it
  task automatic waitLvl(input logic pickBridge, input logic lvl);
    for (k = 0; k < 100 && (pickBridge ? bridge : neutral) !== lvl; k++) @(posedge mclk);
  endtask
  function automatic int clip(input int v, input int l);
    return v > l ? l : (v < -l ? -l : v);
  endfunction
  // Feed-forward plus banded proportional, saturated at the maximum
  function automatic int expFlow(input int err, input int w);
    int ff;
    ff = (w * s) >>> 10;
    return clip(ff + clip((err * g * 205) >>> 11, clip(b + (ff < 0 ? -ff : ff), m)), m);
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {awValid, wValid, bReady, arValid, rReady, useMdl} = '0;
    {awAddr, arAddr, wData, sp, tbPos, ws, absPos, sens} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      axiRd(12'(4 * i));
      check(d, rstTab[i]);
    end
    axiRd(12'h040);
    check(resp, RESP_SLVERR);
    axiWr(12'h040, 5);
    check(resp, RESP_SLVERR);
    repeat (400) @(posedge mclk);
    check(bridge, 1);
    for (int i = 0; i < 24; i++) begin
      g = (i == 0) ? 0 : {$random(seed)} % 201;
      m = {$random(seed)} % 1001;
      b = (i == 1) ? m : {$random(seed)} % (m + 1);
      s = 10 + {$random(seed)} % 7991;
      e = {$random(seed)} % 401;
      axiWr(OFS_GAIN, g); axiWr(OFS_MAX_FLOW, m); axiWr(OFS_BASE_FLOW, b);
      axiWr(OFS_STROKE, s);
      tbPos <= 16'sd100; sp <= 16'(100 + e); ws <= 16'({$random(seed)} % 301);
      repeat (3) @(posedge mclk);
      check(32'(flow), expFlow(e, ws));
    end
    axiRd(OFS_GAIN);
    check(d, g);
    g = 50; m = 1000; b = 100; s = 600;
    axiWr(OFS_GAIN, g); axiWr(OFS_MAX_FLOW, m); axiWr(OFS_BASE_FLOW, b);
    sens <= 16'd400; absPos <= 16'sd200; sp <= 16'sd100; ws <= '0;
    axiWr(OFS_DRIFT_GAIN, 64); repeat (3) @(posedge mclk);
    check(sensAdj, 440);
    axiWr(OFS_DRIFT_GAIN, 0); repeat (3) @(posedge mclk);
    check(sensAdj, 400);
    axiWr(OFS_HOLD_TIME, 2); axiWr(OFS_RELEASE, 3);
    check(resp, RESP_OKAY);
    waitLvl(1'b0, 1'b1);
    check(neutral, 1);
    waitLvl(1'b1, 1'b0);
    check(bridge, 0);
    axiRd(OFS_STATUS);
    check(d, 32'h0000_0001);
    sp <= 16'sd200; repeat (4) @(posedge mclk);
    check({neutral, bridge}, 2'b01);
    useMdl <= 1'b1; sp <= actPos + 16'sd300; repeat (1000) @(posedge mclk);
    check(32'(flow), expFlow(sp - actPos, 0));
    axiRd(OFS_FLOW_CMD);
    check(d, expFlow(sp - actPos, 0));
    axiWr(OFS_CONTROL, 1);
    axiRd(OFS_CONTROL);
    check(d, 1);
    for (e = 0; e < 500 && strobe !== 1'b1; e++) @(posedge mclk);
    @(posedge mclk);
    for (e = 1; e < 500 && strobe !== 1'b1; e++) @(posedge mclk);
    check(e >= 400 && e <= 404, 1);
    test_done();
  end
endmodule // spl_position_loop_bench

// file: bench/spl_valve_model.sv
// Valve spool and actuator model: moves the actuator by the commanded flow.
// Assumes flow in tenths of percent, one step per clock.
`timescale 1ns/1ps
module spl_valve_model
  import spl_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic signed [15:0] flowCmd,
  input  wire logic               spoolNeutral,
  input  wire logic               bridgeEnable,
  output logic signed [15:0]      actPos
);
  initial actPos = 16'sh0000;
  // Oil moves only when energised and out of neutral; small positive flows stall
  always @(posedge mclk) begin
    if (bridgeEnable && !spoolNeutral) actPos <= actPos + (flowCmd >>> 6);
  end
endmodule // spl_valve_model

// file: core/spl_ms_timer.sv
// Millisecond delay counter with restart whenever its condition drops.
// Assumes a one-cycle tick enable at 1 ms from the owner.
`timescale 1ns/1ps
module spl_ms_timer
  import spl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic [15:0] limitMs,
  output logic             done
);

  spl_timer_t st_r;
  spl_timer_t st_nxt;

  // ----------------------------------------------------------------------
  // Count ticks while run holds, restart otherwise
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (tick && st_r.cnt < limitMs) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    st_nxt.done = run && (st_nxt.cnt >= limitMs);  // Saturates, no wrap
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;

endmodule // spl_ms_timer

// file: core/spl_pkg.sv
// Constants, register map and state carriers for the steering position loop.
// Assumes one 25 MHz clock; every millisecond delay runs on a derived tick.
package spl_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_HZ     = 25_000_000;
  localparam int TICK_PERIOD_US  = 1000;
  localparam int TICK_CYCLES     = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam logic [15:0] STATUS_PERIOD_MS = 16'h0028;  // Status resend interval
  localparam logic [15:0] RELEASE_OFF_MS   = 16'h7530;  // Off-delay disabled value

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [5:0] OFS_GAIN       = 6'h00;
  localparam logic [5:0] OFS_MAX_FLOW   = 6'h04;
  localparam logic [5:0] OFS_BASE_FLOW  = 6'h08;
  localparam logic [5:0] OFS_STROKE     = 6'h0C;
  localparam logic [5:0] OFS_DRIFT_GAIN = 6'h10;
  localparam logic [5:0] OFS_DRIFT_LIM  = 6'h14;
  localparam logic [5:0] OFS_HOLD_TIME  = 6'h18;
  localparam logic [5:0] OFS_THRESHOLD  = 6'h1C;
  localparam logic [5:0] OFS_RELEASE    = 6'h20;
  localparam logic [5:0] OFS_CONTROL    = 6'h24;
  localparam logic [5:0] OFS_FLOW_CMD   = 6'h28;
  localparam logic [5:0] OFS_STATUS     = 6'h2C;
  localparam int ADDR_MSB = 11;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_GAIN       = 16'h0032;
  localparam logic [15:0] RST_MAX_FLOW   = 16'h03E8;
  localparam logic [15:0] RST_BASE_FLOW  = 16'h0064;
  localparam logic [15:0] RST_STROKE     = 16'h0258;
  localparam logic [15:0] RST_DRIFT_GAIN = 16'h0000;
  localparam logic [15:0] RST_DRIFT_LIM  = 16'h000A;
  localparam logic [15:0] RST_HOLD_TIME  = 16'h0BB8;
  localparam logic [15:0] RST_THRESHOLD  = 16'h0032;
  localparam logic [15:0] RST_RELEASE    = 16'h7530;

  // ----------------------------------------------------------------------
  // Fixed-point scaling (multiply then shift, replaces division)
  // ----------------------------------------------------------------------
  localparam logic [15:0] DIV10_MUL   = 16'h00CD;  // 205/2048 ~ 1/10
  localparam int          DIV10_SH    = 11;
  localparam int          FF_SH       = 10;        // Wheel speed x stroke scaling
  localparam int          DRIFT_SH    = 6;         // Drift gain scaling
  localparam logic [15:0] DIV100_MUL  = 16'h0029;  // 41/4096 ~ 1/100
  localparam int          DIV100_SH   = 12;
  localparam logic [15:0] DIV1000_MUL = 16'h0083;  // 131/131072 ~ 1/1000
  localparam int          DIV1000_SH  = 17;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cnt;
    logic        done;
  } spl_timer_t;

  typedef struct packed {
    logic [15:0]        gain;
    logic [15:0]        maxFlow;
    logic [15:0]        baseFlow;
    logic [15:0]        stroke;
    logic [15:0]        driftGain;
    logic [15:0]        driftLim;
    logic [15:0]        holdTime;
    logic [15:0]        threshold;
    logic [15:0]        relDelay;
    logic               reportReq;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
    logic signed [15:0] flow;
    logic [15:0]        sensAdj;
    logic               spoolNeutral;
    logic               bridgeEn;
    logic               statusPulse;
    logic [15:0]        tickCnt;
    logic               tick;
  } spl_state_t;

endpackage

// file: core/spl_position_loop.sv
// Steering actuator position loop: flow command, spool neutral, bridge enable.
// Assumes inputs synchronous to mclk; registers reached over AXI4-Lite.
`timescale 1ns/1ps
module spl_position_loop
  import spl_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_MSB:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_MSB:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Loop inputs
  input  wire logic signed [15:0]  posSetpoint,
  input  wire logic signed [15:0]  posMeasured,
  input  wire logic signed [15:0]  wheelSpeed,
  input  wire logic signed [15:0]  wheelAbsPos,
  input  wire logic [15:0]         sensitivity,
  // Valve side
  output logic signed [15:0]       flowCmd,
  output logic                     spoolNeutral,
  output logic                     bridgeEnable,
  output logic [15:0]              sensitivityAdj,
  output logic                     statusStrobe
);

  spl_state_t st_r;
  spl_state_t st_nxt;

  logic neutralDone;
  logic releaseDone;
  logic statusDone;

  // ----------------------------------------------------------------------
  // Datapath helpers
  // ----------------------------------------------------------------------
  logic signed [47:0] errFull;
  logic signed [47:0] propRaw;
  logic signed [47:0] ffRaw;
  logic signed [47:0] bandVal;
  logic signed [47:0] propBand;
  logic signed [47:0] maxVal;
  logic signed [47:0] sumVal;
  logic signed [47:0] ffSat;
  logic signed [47:0] flowSat;
  logic signed [47:0] driftReq;
  logic signed [47:0] driftLimVal;
  logic signed [47:0] driftCl;
  logic signed [47:0] thrFlow;
  logic signed [47:0] flowMag;
  logic               flowInside;
  logic               releaseActive;

  // Symmetric clip of a wide value
  function automatic logic signed [47:0] clip(input logic signed [47:0] v,
                                              input logic signed [47:0] lim);
    if (v > lim) begin
      clip = lim;
    end else if (v < -lim) begin
      clip = -lim;
    end else begin
      clip = v;
    end
  endfunction

  // Flow computation; no accumulator anywhere, so no integral action
  always_comb begin
    errFull  = 48'(posSetpoint) - 48'(posMeasured);
    // Gain in hundredths of percent per tenth percent error, flow in tenths
    propRaw  = (errFull * $signed({32'h0, st_r.gain}) * $signed({32'h0, DIV10_MUL}))
               >>> DIV10_SH;
    ffRaw    = (48'(wheelSpeed) * $signed({32'h0, st_r.stroke})) >>> FF_SH;
    maxVal   = $signed({32'h0, st_r.maxFlow});
    ffSat    = clip(ffRaw, maxVal);
    if (st_r.baseFlow == st_r.maxFlow) begin
      bandVal = maxVal;
    end else begin
      bandVal = $signed({32'h0, st_r.baseFlow}) + (ffRaw < 0 ? -ffRaw : ffRaw);
      if (bandVal > maxVal) begin
        bandVal = maxVal;
      end
    end
    propBand = clip(propRaw, bandVal);
    sumVal   = ffRaw + propBand;
    flowSat  = clip(sumVal, maxVal);
  end

  // Drift compensation on sensitivity (turns x 100)
  always_comb begin
    driftReq    = ((48'(wheelAbsPos) - 48'(posMeasured))
                  * $signed({32'h0, st_r.driftGain})) >>> DRIFT_SH;
    driftLimVal = ($signed({32'h0, sensitivity}) * $signed({32'h0, st_r.driftLim})
                  * $signed({32'h0, DIV100_MUL})) >>> DIV100_SH;
    driftCl     = clip(driftReq, driftLimVal);
  end

  // Steady-state window on the registered command
  always_comb begin
    thrFlow       = ($signed({32'h0, st_r.threshold}) * maxVal
                    * $signed({32'h0, DIV1000_MUL})) >>> DIV1000_SH;
    flowMag       = (st_r.flow < 0) ? -48'(st_r.flow) : 48'(st_r.flow);
    flowInside    = flowMag <= thrFlow;
    releaseActive = st_r.relDelay != RELEASE_OFF_MS;
  end

  // ----------------------------------------------------------------------
  // Delay timers
  // ----------------------------------------------------------------------
  spl_ms_timer u_neutral (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .tick    (st_r.tick),
    .run     (flowInside),
    .limitMs (st_r.holdTime),
    .done    (neutralDone)
  );

  spl_ms_timer u_release (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .tick    (st_r.tick),
    .run     (st_r.flow == 16'sh0000),
    .limitMs (st_r.relDelay),
    .done    (releaseDone)
  );

  // Restarts itself one cycle after each expiry
  spl_ms_timer u_status (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .tick    (st_r.tick),
    .run     (st_r.reportReq && !statusDone),
    .limitMs (STATUS_PERIOD_MS),
    .done    (statusDone)
  );

  // ----------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------
  function automatic logic [32:0] readReg(input logic [ADDR_MSB:0] a,
                                          input spl_state_t s);
    logic [31:0] d;
    logic        ok;
    d  = '0;
    ok = 1'b1;
    if (a[ADDR_MSB:6] != '0 || a[1:0] != 2'h0) begin
      ok = 1'b0;
    end else begin
      case (a[5:0])
        OFS_GAIN:       d[15:0] = s.gain;
        OFS_MAX_FLOW:   d[15:0] = s.maxFlow;
        OFS_BASE_FLOW:  d[15:0] = s.baseFlow;
        OFS_STROKE:     d[15:0] = s.stroke;
        OFS_DRIFT_GAIN: d[15:0] = s.driftGain;
        OFS_DRIFT_LIM:  d[15:0] = s.driftLim;
        OFS_HOLD_TIME:  d[15:0] = s.holdTime;
        OFS_THRESHOLD:  d[15:0] = s.threshold;
        OFS_RELEASE:    d[15:0] = s.relDelay;
        OFS_CONTROL:    d[0]    = s.reportReq;
        OFS_FLOW_CMD:   d[15:0] = s.flow;
        OFS_STATUS:     d[2:0]  = {s.statusPulse, s.bridgeEn, s.spoolNeutral};
        default:        ok      = 1'b0;
      endcase
    end
    readReg = {ok, d};
  endfunction

  // Byte-lane merge into a 16-bit field
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = old;
    if (be[0]) begin
      merge[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge[15:8] = wd[15:8];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  logic        wrGo;
  logic        wrOk;
  logic [32:0] rdWord;

  always_comb begin
    st_nxt = st_r;
    wrGo   = 1'b0;
    wrOk   = 1'b1;
    rdWord = readReg(s_axi_araddr, st_r);

    // 1 ms tick divider
    st_nxt.tick = 1'b0;
    if (st_r.tickCnt == 16'(TICK_DIV - 1)) begin
      st_nxt.tickCnt = '0;
      st_nxt.tick    = 1'b1;
    end else begin
      st_nxt.tickCnt = st_r.tickCnt + 16'h0001;
    end

    // Write channel: both address and data must be present together
    st_nxt.awready = 1'b0;
    st_nxt.wready  = 1'b0;
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_wvalid && !st_r.bvalid && !st_r.awready) begin
      wrGo           = 1'b1;
      st_nxt.awready = 1'b1;
      st_nxt.wready  = 1'b1;
      st_nxt.bvalid  = 1'b1;
      if (s_axi_awaddr[ADDR_MSB:6] != '0 || s_axi_awaddr[1:0] != 2'h0) begin
        wrOk = 1'b0;
      end else begin
        case (s_axi_awaddr[5:0])
          OFS_GAIN:       st_nxt.gain      = merge(st_r.gain, s_axi_wdata, s_axi_wstrb);
          OFS_MAX_FLOW:   st_nxt.maxFlow   = merge(st_r.maxFlow, s_axi_wdata, s_axi_wstrb);
          OFS_BASE_FLOW:  st_nxt.baseFlow  = merge(st_r.baseFlow, s_axi_wdata, s_axi_wstrb);
          OFS_STROKE:     st_nxt.stroke    = merge(st_r.stroke, s_axi_wdata, s_axi_wstrb);
          OFS_DRIFT_GAIN: st_nxt.driftGain = merge(st_r.driftGain, s_axi_wdata, s_axi_wstrb);
          OFS_DRIFT_LIM:  st_nxt.driftLim  = merge(st_r.driftLim, s_axi_wdata, s_axi_wstrb);
          OFS_HOLD_TIME:  st_nxt.holdTime  = merge(st_r.holdTime, s_axi_wdata, s_axi_wstrb);
          OFS_THRESHOLD:  st_nxt.threshold = merge(st_r.threshold, s_axi_wdata, s_axi_wstrb);
          OFS_RELEASE:    st_nxt.relDelay  = merge(st_r.relDelay, s_axi_wdata, s_axi_wstrb);
          OFS_CONTROL: begin
            if (s_axi_wstrb[0]) begin
              st_nxt.reportReq = s_axi_wdata[0];
            end
          end
          OFS_FLOW_CMD, OFS_STATUS: wrOk = 1'b1;  // Read-only, write ignored
          default:        wrOk = 1'b0;
        endcase
      end
      st_nxt.bresp = wrOk ? RESP_OKAY : RESP_SLVERR;
    end

    // Read channel, one outstanding read
    st_nxt.arready = 1'b0;
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_r.rvalid && !st_r.arready) begin
      st_nxt.arready = 1'b1;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rdata   = rdWord[31:0];
      st_nxt.rresp   = rdWord[32] ? RESP_OKAY : RESP_SLVERR;
    end

    // Valve side outputs
    st_nxt.flow         = flowSat[15:0];
    st_nxt.sensAdj      = 16'($signed({32'h0, sensitivity}) + driftCl);
    st_nxt.spoolNeutral = neutralDone && flowInside;
    st_nxt.bridgeEn     = (st_r.flow != 16'sh0000)
                          || !(releaseActive && releaseDone);
    st_nxt.statusPulse  = statusDone;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r           <= '0;
      st_r.gain      <= RST_GAIN;
      st_r.maxFlow   <= RST_MAX_FLOW;
      st_r.baseFlow  <= RST_BASE_FLOW;
      st_r.stroke    <= RST_STROKE;
      st_r.driftGain <= RST_DRIFT_GAIN;
      st_r.driftLim  <= RST_DRIFT_LIM;
      st_r.holdTime  <= RST_HOLD_TIME;
      st_r.threshold <= RST_THRESHOLD;
      st_r.relDelay  <= RST_RELEASE;
      st_r.bridgeEn  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready  = st_r.awready;
  assign s_axi_wready   = st_r.wready;
  assign s_axi_bvalid   = st_r.bvalid;
  assign s_axi_bresp    = st_r.bresp;
  assign s_axi_arready  = st_r.arready;
  assign s_axi_rvalid   = st_r.rvalid;
  assign s_axi_rresp    = st_r.rresp;
  assign s_axi_rdata    = st_r.rdata;
  assign flowCmd        = st_r.flow;
  assign spoolNeutral   = st_r.spoolNeutral;
  assign bridgeEnable   = st_r.bridgeEn;
  assign sensitivityAdj = st_r.sensAdj;
  assign statusStrobe   = st_r.statusPulse;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_GAIN_ZERO: assert property (
    st_r.gain == 16'h0000 && $stable(st_r.gain) |=> st_r.flow == $past(ffSat[15:0]))
    else $error("zero gain left a closed-loop share in the flow");

  AST_MAX_CLIP: assert property (
    $past(st_r.maxFlow) == st_r.maxFlow |->
      (st_r.flow <= $signed({1'b0, st_r.maxFlow[14:0]})
       && st_r.flow >= -$signed({1'b0, st_r.maxFlow[14:0]})))
    else $error("flow command outside maximum flow");

  AST_BAND_CONST: assert property (
    st_r.baseFlow == st_r.maxFlow |-> bandVal == maxVal)
    else $error("band varies although base equals maximum");

  AST_NEUTRAL_EXIT: assert property (
    !flowInside |=> !st_r.spoolNeutral)
    else $error("spool stayed neutral above threshold");

  AST_BRIDGE_ON: assert property (
    st_r.flow != 16'sh0000 |=> st_r.bridgeEn)
    else $error("bridge not enabled on non-zero flow");

  AST_BRIDGE_DEFAULT: assert property (
    !releaseActive ##1 !releaseActive |-> st_r.bridgeEn)
    else $error("bridge dropped with off-delay inactive");

  AST_DRIFT_OFF: assert property (
    st_r.driftGain == 16'h0000 |=> st_r.sensAdj == $past(sensitivity))
    else $error("sensitivity changed with drift gain zero");

  AST_STATUS_QUIET: assert property (
    !st_r.reportReq [*3] |-> !st_r.statusPulse)
    else $error("status pulse without a request");

  AST_WRITE_RESP: assert property (
    wrGo |=> st_r.bvalid && st_r.awready && st_r.wready)
    else $error("write taken without response");

endmodule // spl_position_loop
